// File: rtd_pkg.sv
// Purpose: shared constants for the discharge temperature sequencer
// Assumes: 40 MHz system clock
// Notes:   byte addresses on a 32-bit classic Wishbone slave
package rtd_pkg;
	localparam int CLK_MHZ = 40;
	// register byte addresses
	localparam logic [7:0] ADR_CFG   = 8'h00;
	localparam logic [7:0] ADR_CMD   = 8'h04;
	localparam logic [7:0] ADR_STAT  = 8'h08;
	localparam logic [7:0] ADR_MASK  = 8'h0C;
	localparam logic [7:0] ADR_STATE = 8'h10;
	localparam logic [7:0] ADR_RES0  = 8'h20;
	localparam logic [31:0] CFG_RST  = 32'h00000000;
	// config word field positions
	localparam int BIT_CYCLE_LSB  = 14;
	localparam int BIT_MAINS      = 17;
	localparam int BIT_ORDER      = 20;
	localparam int BIT_PORTS      = 21;
	localparam int BIT_WARM       = 22;
	localparam int BIT_TCYC       = 23;
	localparam int BIT_SETTLE_LSB = 24;
	// opcodes written to the command register
	localparam logic [7:0] OP_TEMP     = 8'h02;
	localparam logic [7:0] OP_TEMP_RPT = 8'h04;
	// status bit positions
	localparam int EV_DONE  = 0;
	localparam int EV_SHORT = 1;
	localparam int EV_OPEN  = 2;
	localparam logic [31:0] RES_OPEN  = 32'hFFFFFFFF;
	localparam logic [31:0] RES_SHORT = 32'h00000000;
	localparam logic [2:0] WARM_FEW  = 3'h2;
	localparam logic [2:0] WARM_MANY = 3'h7;
	// times and derived cycle counts
	localparam int TCYC_A_NS  = 128000;
	localparam int TCYC_B_NS  = 512000;
	localparam int TCYC_A_CYC = TCYC_A_NS * CLK_MHZ / 1000;
	localparam int TCYC_B_CYC = TCYC_B_NS * CLK_MHZ / 1000;
	localparam int TREF_NS    = 250;
	localparam int SHORT_NS   = 8 * TREF_NS;
	localparam int SHORT_CYC  = (SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int MAINS50_NS = 20000000;
	localparam int MAINS60_NS = 16666667;
	localparam int Q50_CYC    = MAINS50_NS / 4 * CLK_MHZ / 1000;
	localparam int Q60_CYC    = MAINS60_NS / 4 * CLK_MHZ / 1000;
	localparam int SET2_NS    = 480000;
	localparam int SET3_NS    = 1460000;
	localparam int SET4_NS    = 2440000;
	localparam int SET5_NS    = 5140000;
	localparam int SET2_CYC   = SET2_NS * CLK_MHZ / 1000;
	localparam int SET3_CYC   = SET3_NS * CLK_MHZ / 1000;
	localparam int SET4_CYC   = SET4_NS * CLK_MHZ / 1000;
	localparam int SET5_CYC   = SET5_NS * CLK_MHZ / 1000;
	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_SETTLE = 3'h1,
		S_WARM   = 3'h3,
		S_MEAS   = 3'h2,
		S_GAP    = 3'h6
	} seq_t;
endpackage : rtd_pkg

// File: rtd_discharge_temp_sequencer.sv
// Purpose: capacitor discharge temperature sequencer with Wishbone slave
// Assumes: comparator stop input is asynchronous; config changes apply
//          at the next start, except oscEn, which follows a settle field of 1 at once
// Notes:   interrupt output is low while an unmasked status bit is set
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RL1] one start opcode runs warm-up, port timing and storage unaided
// [RL2] repeat opcode runs two measurements split by a mains-based delay
// [RL3] two or seven discarded warm-up discharges on the first port
// [RL4] done flag only after the last port of the sequence
// [RL5] bit 20 picks ascending or descending port order
// [RL6] each port result goes to its own result register
// [RL7] bit 22 selects two or seven warm-up discharges
// [RL8] bit 23 selects 128 or 512 us cycle per port
// [RL9] port count bit selects two or four ports
// [RL10] with four ports every port needs a resistor, else open errors
// [RL11] mains bit picks 50 or 60 Hz; field gives 0.25..2 periods
// [RL12] host keeps cycle time below the measurement timeout
// [RL13] discharge under eight reference periods stores zero as short
// [RL14] no stop within the cycle stores all ones as open
// [RL15] host sets second timeout to 2 ms with long cycle
// [RL16] host picks long cycle for 500 or 1000 ohm sensors
// [RL17] completion drives the active-low interrupt output low
// [RL18] settle setting above one delays measuring after start
module rtd_discharge_temp_sequencer #(
	parameter int CNT_W  = 24,
	parameter int TCYC_A = rtd_pkg::TCYC_A_CYC,
	parameter int TCYC_B = rtd_pkg::TCYC_B_CYC,
	parameter int Q50    = rtd_pkg::Q50_CYC,
	parameter int Q60    = rtd_pkg::Q60_CYC,
	parameter int SET2   = rtd_pkg::SET2_CYC,
	parameter int SET3   = rtd_pkg::SET3_CYC,
	parameter int SET4   = rtd_pkg::SET4_CYC,
	parameter int SET5   = rtd_pkg::SET5_CYC
) (
	// clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// discharge front end
	input  wire logic        compStop,
	output logic      [3:0]  portSel,
	output logic             dischargeStart,
	output logic             oscEn,
	// interrupt
	output logic             irq_n_out
);
	import rtd_pkg::*;

	function automatic logic [31:0] byteMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : byteMerge

	seq_t               state_r;
	seq_t               state_nxt;
	logic               ack_r;
	logic [31:0]        cfg_r;
	logic [31:0]        cfgRun_r;
	logic [2:0]         stat_r;
	logic [2:0]         mask_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [CNT_W-1:0]   cnt_nxt;
	logic [2:0]         warmLeft_r;
	logic [2:0]         warmLeft_nxt;
	logic [1:0]         portIdx_r;
	logic [1:0]         portIdx_nxt;
	logic [2:0]         qLeft_r;
	logic [2:0]         qLeft_nxt;
	logic               pass2_r;
	logic               pass2_nxt;
	logic [2:0]         sync_r;
	logic               stopLvl_r;
	logic               stopSeen_r;
	logic [CNT_W-1:0]   stopCnt_r;
	logic [31:0]        res_r [4];
	logic [31:0]        rdData;

	// bus decode
	wire logic wbReq   = cyc_i & stb_i & ~ack_r;
	wire logic wr      = wbReq & we_i;
	wire logic wrCfg   = wr & (adr_i == ADR_CFG);
	wire logic wrCmd   = wr & (adr_i == ADR_CMD) & sel_i[0];
	wire logic wrStat  = wr & (adr_i == ADR_STAT) & sel_i[0];
	wire logic wrMask  = wr & (adr_i == ADR_MASK);
	wire logic isRes   = (adr_i[7:4] == ADR_RES0[7:4]) & (adr_i[1:0] == 2'h0);
	wire logic opOne   = dat_i[7:0] == OP_TEMP;
	wire logic opRpt   = dat_i[7:0] == OP_TEMP_RPT;
	wire logic startOk = wrCmd & (opOne | opRpt) & (state_r == S_IDLE);

	// settings
	wire logic [2:0] setSel   = cfg_r[BIT_SETTLE_LSB +: 3];
	wire logic [2:0] warmLoad = cfg_r[BIT_WARM] ? WARM_MANY : WARM_FEW;
	wire logic [2:0] warmRun  = cfgRun_r[BIT_WARM] ? WARM_MANY : WARM_FEW;
	wire logic       orderRev = cfgRun_r[BIT_ORDER];
	wire logic [1:0] lastIdx  = cfgRun_r[BIT_PORTS] ? 2'h3 : 2'h1;
	wire logic [2:0] gapField = cfgRun_r[BIT_CYCLE_LSB +: 3];
	wire logic [CNT_W-1:0] cycLim = cfgRun_r[BIT_TCYC] ? // RL8
		CNT_W'(TCYC_B) : CNT_W'(TCYC_A);
	wire logic [CNT_W-1:0] qLim = cfgRun_r[BIT_MAINS] ?
		CNT_W'(Q60) : CNT_W'(Q50);
	wire logic [2:0] runSet = cfgRun_r[BIT_SETTLE_LSB +: 3];
	wire logic [CNT_W-1:0] setLim = (runSet == 3'h2) ? CNT_W'(SET2) :
		(runSet == 3'h3) ? CNT_W'(SET3) :
		(runSet == 3'h4) ? CNT_W'(SET4) : CNT_W'(SET5);

	// discharge timing
	wire logic timing  = (state_r == S_WARM) | (state_r == S_MEAS);
	wire logic cycEnd  = timing & (cnt_r == cycLim - 1'b1);
	wire logic measEnd = cycEnd & (state_r == S_MEAS);
	wire logic [1:0] physPort = orderRev ? ~portIdx_r : portIdx_r; // RL5
	wire logic stopEdge = sync_r[1] & sync_r[2] & ~stopLvl_r;
	wire logic isShort = stopSeen_r & (stopCnt_r < CNT_W'(SHORT_CYC));
	wire logic [31:0] measVal = !stopSeen_r ? RES_OPEN : // RL14
		isShort ? RES_SHORT : // RL13
		{{(32-CNT_W){1'b0}}, stopCnt_r};
	wire logic doneEv  = measEnd & (portIdx_r == lastIdx) & ~pass2_r; // RL4
	wire logic [2:0] evSet = {measEnd & ~stopSeen_r, measEnd & isShort,
		doneEv};
	wire logic [2:0] evClr = wrStat ? dat_i[2:0] : 3'h0;

	assign portSel        = timing ? (4'h1 << physPort) : 4'h0;
	assign dischargeStart = timing & (cnt_r == '0);
	assign oscEn          = (state_r != S_IDLE) | (setSel == 3'h1); // RL18
	assign irq_n_out      = ~|(stat_r & mask_r); // RL17
	assign ack_o          = ack_r;
	assign rdData = (adr_i == ADR_CFG)   ? cfg_r :
		(adr_i == ADR_STAT)  ? {29'h0, stat_r} :
		(adr_i == ADR_MASK)  ? {29'h0, mask_r} :
		(adr_i == ADR_STATE) ? {26'h0, pass2_r, portIdx_r, state_r} :
		isRes ? res_r[adr_i[3:2]] : 32'h0;

	always_comb begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r + 1'b1;
		warmLeft_nxt = warmLeft_r;
		portIdx_nxt  = portIdx_r;
		qLeft_nxt    = qLeft_r;
		pass2_nxt    = pass2_r;
		case (state_r)
			S_IDLE: begin
				cnt_nxt = '0;
				if (startOk) begin // RL1
					pass2_nxt    = opRpt; // RL2
					portIdx_nxt  = 2'h0;
					warmLeft_nxt = warmLoad; // RL7
					state_nxt    = (setSel > 3'h1) ? S_SETTLE : S_WARM; // RL18
				end
			end
			S_SETTLE: begin
				if (cnt_r == setLim - 1'b1) begin
					cnt_nxt   = '0;
					state_nxt = S_WARM;
				end
			end
			S_WARM: begin
				if (cycEnd) begin // RL3
					cnt_nxt      = '0;
					warmLeft_nxt = warmLeft_r - 1'b1;
					if (warmLeft_r == 3'h1) begin
						state_nxt = S_MEAS;
					end
				end
			end
			S_MEAS: begin
				if (cycEnd) begin
					cnt_nxt     = '0;
					portIdx_nxt = portIdx_r + 1'b1;
					if (portIdx_r == lastIdx) begin // RL9
						portIdx_nxt = 2'h0;
						pass2_nxt   = 1'b0;
						qLeft_nxt   = gapField;
						state_nxt   = pass2_r ? S_GAP : S_IDLE;
					end
				end
			end
			S_GAP: begin
				if (cnt_r == qLim - 1'b1) begin // RL11
					cnt_nxt   = '0;
					qLeft_nxt = qLeft_r - 1'b1;
					if (qLeft_r == 3'h0) begin
						warmLeft_nxt = warmRun;
						state_nxt    = S_WARM;
					end
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r    <= S_IDLE;
			cnt_r      <= '0;
			warmLeft_r <= 3'h0;
			portIdx_r  <= 2'h0;
			qLeft_r    <= 3'h0;
			pass2_r    <= 1'b0;
		end else if (ce) begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			warmLeft_r <= warmLeft_nxt;
			portIdx_r  <= portIdx_nxt;
			qLeft_r    <= qLeft_nxt;
			pass2_r    <= pass2_nxt;
		end
	end

	// bus registers; hardware set wins over write-one clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r    <= 1'b0;
			dat_o    <= 32'h0;
			cfg_r    <= CFG_RST;
			cfgRun_r <= CFG_RST;
			stat_r   <= 3'h0;
			mask_r   <= 3'h0;
		end else if (ce) begin
			ack_r  <= wbReq;
			dat_o  <= wbReq ? rdData : dat_o;
			cfg_r  <= wrCfg ? byteMerge(cfg_r, dat_i, sel_i) : cfg_r;
			stat_r <= (stat_r & ~evClr) | evSet;
			mask_r <= (wrMask & sel_i[0]) ? dat_i[2:0] : mask_r;
			if (startOk) begin
				cfgRun_r <= cfg_r;
			end
		end
	end

	// stop pin: three stages, level changes when stages two and three agree
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_r     <= 3'h0;
			stopLvl_r  <= 1'b0;
			stopSeen_r <= 1'b0;
			stopCnt_r  <= '0;
		end else if (ce) begin
			sync_r <= {sync_r[1:0], compStop};
			if (sync_r[1] == sync_r[2]) begin
				stopLvl_r <= sync_r[2];
			end
			stopSeen_r <= timing & ~cycEnd & (stopSeen_r | stopEdge);
			if (timing & stopEdge & ~stopSeen_r) begin
				stopCnt_r <= cnt_r;
			end
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_res
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				res_r[g] <= 32'h0;
			end else if (ce & measEnd & (physPort == 2'(g))) begin
				res_r[g] <= measVal; // RL6
			end
		end
	end

	a_start_runs: assert property (@(posedge sys_clk) disable iff (rst) // RL1
		ce && startOk |=> state_r != S_IDLE)
		else $error("start opcode ignored");
	a_repeat_gap: assert property (@(posedge sys_clk) disable iff (rst) // RL2
		ce && measEnd && pass2_r && portIdx_r == lastIdx |=> state_r == S_GAP)
		else $error("repeat did not enter delay");
	a_warm_first: assert property (@(posedge sys_clk) disable iff (rst) // RL3
		state_r == S_WARM |-> portSel == (orderRev ? 4'h8 : 4'h1))
		else $error("warm-up on wrong port");
	a_warm_count: assert property (@(posedge sys_clk) disable iff (rst) // RL7
		ce && startOk |=> warmLeft_r == (cfgRun_r[BIT_WARM] ? 3'h7 : 3'h2))
		else $error("warm-up count wrong");
	a_done_last: assert property (@(posedge sys_clk) disable iff (rst) // RL4
		ce && evSet[EV_DONE] |-> state_r == S_MEAS && portIdx_r == lastIdx)
		else $error("done before last port");
	a_port_span: assert property (@(posedge sys_clk) disable iff (rst) // RL9
		state_r == S_MEAS |-> portIdx_r <= lastIdx)
		else $error("port index beyond count");
	a_short_zero: assert property (@(posedge sys_clk) disable iff (rst) // RL13
		ce && measEnd && isShort |=> res_r[$past(physPort)] == 32'h0)
		else $error("short not stored as zero");
	a_open_ones: assert property (@(posedge sys_clk) disable iff (rst) // RL14
		ce && measEnd && !stopSeen_r |=> res_r[$past(physPort)] == RES_OPEN)
		else $error("open not stored as all ones");
	a_irq_done: assert property (@(posedge sys_clk) disable iff (rst) // RL17
		ce && doneEv && mask_r[EV_DONE] |=> !irq_n_out)
		else $error("interrupt not asserted on done");
	a_settle_go: assert property (@(posedge sys_clk) disable iff (rst) // RL18
		ce && startOk && setSel > 3'h1 |=> state_r == S_SETTLE)
		else $error("settle delay skipped");
endmodule : rtd_discharge_temp_sequencer
`default_nettype wire

// File: rtd_sensor_model.sv
// Purpose: behavioural comparator and resistor network on the far side
// Assumes: per-port stop delay in clocks, zero means nothing attached
// Notes:   stop stays high until the next discharge or deselect
`timescale 1ns/1ps
`default_nettype none
module rtd_sensor_model (
	// clock
	input  wire logic        sys_clk,
	// front end
	input  wire logic [3:0]  portSel,
	input  wire logic        dischargeStart,
	input  wire logic [63:0] stopDly,
	output logic             compStop
);
	logic [15:0] cnt_r;
	logic [15:0] lim_r;
	wire  [1:0]  portIdx = {portSel[3] | portSel[2], portSel[3] | portSel[1]};

	initial compStop = 1'b0;
	initial cnt_r = 16'h0000;
	initial lim_r = 16'h0000;
	always @(posedge sys_clk) begin
		if (dischargeStart === 1'b1) begin
			cnt_r <= 16'h0001;
			compStop <= 1'b0;
			lim_r <= stopDly[16 * portIdx +: 16];
		end else if (portSel == 4'h0) begin
			compStop <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			// empty port never stops the discharge
			if (lim_r != 16'h0000 && cnt_r == lim_r) compStop <= 1'b1;
		end
	end
endmodule : rtd_sensor_model
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the discharge temperature sequencer
// Assumes: shortened cycle, mains and settle counts via parameters
// Notes:   random configs from a fixed seed plus short/open corner cases
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rtd_pkg::*;
	localparam int TA = 200, TB = 300, QF = 50, QS = 40, S3 = 30;
	logic        sys_clk = 0, rst = 1, ce = 1, cyc_i = 0, stb_i = 0;
	logic        we_i = 0, ack_o, compStop, dischargeStart, oscEn, irq_n_out;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF, portSel;
	logic [31:0] dat_i = 32'h00000000, dat_o, rd, cf;
	logic [15:0] dly [4];
	int          fail_count = 0, tests_run = 0, cnt = 0, early = 0, t0 = 0;
	logic [3:0]  seen [$];
	int          at [$];

	always #12.5 sys_clk = ~sys_clk;
	rtd_discharge_temp_sequencer #(.TCYC_A(TA), .TCYC_B(TB), .Q50(QF),
		.Q60(QS), .SET2(20), .SET3(S3), .SET4(40), .SET5(50))
	rtd_discharge_temp_sequencer_inst (.sys_clk(sys_clk), .rst(rst),
		.ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.compStop(compStop), .portSel(portSel),
		.dischargeStart(dischargeStart), .oscEn(oscEn),
		.irq_n_out(irq_n_out));
	rtd_sensor_model rtd_sensor_model_inst (.sys_clk(sys_clk),
		.portSel(portSel), .dischargeStart(dischargeStart),
		.stopDly({dly[3], dly[2], dly[1], dly[0]}), .compStop(compStop));

	// log every discharge start with its port and time
	always @(negedge sys_clk) begin
		cnt++;
		if (dischargeStart === 1'b1) begin
			seen.push_back(portSel);
			at.push_back(cnt);
			if (irq_n_out !== 1'b1) early++;
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// port that the p-th measured discharge of a pass must select
	function automatic logic [3:0] expPort(input logic [31:0] c, input int p);
		return c[BIT_ORDER] ? 4'(8 >> p) : 4'(1 << p);
	endfunction : expPort

	// start-to-start span across the repeat delay
	function automatic int expGap(input logic [31:0] c, input int per);
		return per + (int'(c[BIT_CYCLE_LSB +: 3]) + 1) *
			(c[BIT_MAINS] ? QS : QF);
	endfunction : expGap

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// classic single cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// ack and read data are taken at the same rising edge
		do begin
			@(posedge sys_clk);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	task automatic run(input logic [31:0] c, input logic [7:0] op);
		int n, np, nw, per, rp, j, p, d;
		np = c[BIT_PORTS] ? 4 : 2;
		nw = c[BIT_WARM] ? 7 : 2;
		per = c[BIT_TCYC] ? TB : TA;
		rp = (op == OP_TEMP_RPT) ? 2 : 1;
		wb(1'b1, ADR_STAT, 32'h00000007);
		wb(1'b1, ADR_MASK, 32'h00000001);
		wb(1'b1, ADR_CFG, c);
		seen.delete();
		at.delete();
		early = 0;
		wb(1'b1, ADR_CMD, {24'h000000, op});
		t0 = cnt;
		chk("osc busy", oscEn, 1'b1);
		n = 0;
		while (irq_n_out !== 1'b0 && n < 30000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq wait", n < 30000, 1'b1);
		chk("osc idle", oscEn, c[BIT_SETTLE_LSB +: 3] == 3'h1);
		chk("pulses", seen.size(), rp * (nw + np));
		chk("early irq", early, 0);
		foreach (seen[k]) begin
			j = k % (nw + np);
			p = (j < nw) ? 0 : j - nw;
			chk("port", seen[k], expPort(c, p));
			if (k == nw + np)
				chk("gap", at[k] - at[k - 1], expGap(c, per));
			else if (k > 0)
				chk("cycle", at[k] - at[k - 1], per);
		end
		wb(1'b0, ADR_STAT, 32'h00000000);
		chk("done", rd[EV_DONE], 1'b1);
		for (p = 0; p < np; p++) begin
			j = c[BIT_ORDER] ? 3 - p : p;
			d = dly[j];
			wb(1'b0, ADR_RES0 + 8'(4 * j), 32'h00000000);
			if (d + 3 < SHORT_CYC)
				chk("err code", rd, d == 0 ? RES_OPEN : RES_SHORT);
			else
				chk("result", (rd + 2 - d) <= 8, 1);
		end
	endtask : run

	initial begin
		void'($urandom(2024));
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		wb(1'b0, ADR_CFG, 32'h00000000);
		chk("cfg reset", rd, CFG_RST);
		wb(1'b0, 8'h3C, 32'h00000000);
		chk("unmapped", rd, 32'h00000000);
		sel_i <= 4'h4;
		wb(1'b1, ADR_CFG, 32'hFFFFFFFF);
		sel_i <= 4'hF;
		wb(1'b0, ADR_CFG, 32'h00000000);
		chk("cfg bytes", rd, 32'h00FF0000);
		chk("irq idle", irq_n_out, 1'b1);
		for (int i = 0; i < 6; i++) begin
			// stops well inside the shortest cycle, no overflow
			foreach (dly[j]) dly[j] = 16'(100 + $urandom % 80);
			cf = $urandom & 32'h00F3C000;
			run(cf, i[0] ? OP_TEMP_RPT : OP_TEMP);
		end
		dly = '{16'd150, 16'd0, 16'd10, 16'd120};
		run(32'h00200000, OP_TEMP);
		wb(1'b0, ADR_STAT, 32'h00000000);
		chk("status", rd, 32'h00000007);
		wb(1'b1, ADR_MASK, 32'h00000000);
		chk("masked irq", irq_n_out, 1'b1);
		wb(1'b1, ADR_STAT, 32'h00000007);
		wb(1'b1, ADR_MASK, 32'h00000007);
		chk("cleared irq", irq_n_out, 1'b1);
		dly = '{16'd160, 16'd140, 16'd130, 16'd110};
		// long cycle with settle delay before the first discharge
		run(32'h03800000, OP_TEMP);
		chk("settle", (at[0] - t0 >= S3 - 4) && (at[0] - t0 <= S3 + 4), 1);
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
